// [pkg/alx_regs.vh]
// Constants for the arithmetic and logic execution control block
`ifndef ALX_REGS_VH
`define ALX_REGS_VH
`define ALX_WORD_W 24
`define ALX_OPF_W 14
`define ALX_ISEL_W 3
`define ALX_ISEL_LSB 15
// Machine phases within one memory cycle
`define ALX_PH_T1 3'h0
`define ALX_PH_T2 3'h1
`define ALX_PH_T3 3'h2
`define ALX_PH_T4 3'h3
`define ALX_PH_T5 3'h4
// Operation codes written to the opcode register
`define ALX_OP_NONE 4'h0
`define ALX_OP_ADD 4'h1
`define ALX_OP_SUB 4'h2
`define ALX_OP_XOR 4'h3
`define ALX_OP_CMP 4'h4
`define ALX_OP_LDA 4'h5
`define ALX_OP_LDE 4'h6
`define ALX_OP_RUM 4'h7
`define ALX_OP_AND 4'h8
`define ALX_OP_OR 4'h9
`define ALX_OP_ATX 4'hA
`define ALX_OP_DNG 4'hB
// AHB-Lite register byte addresses
`define ALX_A_CTRL 8'h00
`define ALX_A_ACC 8'h04
`define ALX_A_EXT 8'h08
`define ALX_A_BUF 8'h0C
`define ALX_A_CMD 8'h10
`define ALX_A_FLAGS 8'h14
`define ALX_A_STAT 8'h18
`define ALX_A_IDX 8'h1C
`define ALX_A_MEM 8'h20
// Flag register bit positions
`define ALX_F_OV 0
`define ALX_F_GT 1
`define ALX_F_EQ 2
`define ALX_F_LT 3
`define ALX_F_BE 4
`define ALX_F_CY 5
`endif

// [core/alx_exec.v]
// Execution control and 24-bit datapath for arithmetic and logic operations
`timescale 1ns/1ps
`default_nettype none
`include "alx_regs.vh"
// Operation
// - Add sets overflow at T5 when like-signed inputs give opposite-signed sum
// - Adder settles until T5; accumulator gets one load pulse at T5
// - Add starts with operand fetch; execution overlaps the next fetch
// - Subtract uses inverted buffer plus carry-inject on add timing
// - Exclusive-or is add with carries suppressed, result to accumulator
// - Compare subtracts; at T5 sets equal, else greater or less by sign
// - Compare sets shared-one flag when accumulator AND operand is nonzero
// - Compare updates flags only; accumulator is not clocked
// - Load accumulator passes operand through adder into accumulator at T5
// - Load extension passes operand through adder into extension at T5
// - Selective replace takes operand bits where extension bit is one
// - And replaces accumulator with accumulator AND operand at T5
// - Or replaces accumulator with accumulator OR operand at T5
// - Index-add sums index and operand field at T5, writes index at T1
// - Index-add clears select bit 15 at T1, keeping bits 17 and 16
// - Index-add execution subtracts even index from operand field, sets flags
// - Index-add first cycle is operand phase without fetch; then normal fetch
// - Double negate complements the 48-bit accumulator:extension pair
// - Double negate first cycle negates extension at T5, saves carry-out
// - Double negate second cycle negates accumulator with saved carry in
// - Every compare sets or resets each comparison flag
// - Operand fetch loads memory word into buffer at T1
// - Command bits 17..15 select index register; zero means none for the index sum and index write, but execution still reads index 0
module alx_exec #(
    parameter W = `ALX_WORD_W,
    parameter OW = `ALX_OPF_W
) (
    input wire ref_clk,
    input wire nrst,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hsel,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [W-1:0] mem_word,
    output reg [2:0] phase_q,
    output wire operand_cycle_phase,
    output wire fetch_cycle_phase,
    output wire execute_phase_one,
    output wire acc_load_pulse,
    output wire extension_load_pulse,
    output wire buffer_load_pulse,
    output wire index_write_strobe
);
    localparam S_IDLE = 2'h0;
    localparam S_OPC = 2'h1;
    localparam S_EXE = 2'h2;

    reg [W-1:0] acc_q, ext_q, buf_q;
    reg [23:0] cmd_q;
    reg [OW-1:0] idx_q [0:7];
    reg [5:0] flags_q;
    reg [3:0] op_q;
    reg [1:0] st_q;
    reg [W-1:0] mem_q;
    reg busy_q;
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg rd_pend_q;
    reg [7:0] rd_addr_q;

    // Shared AU: a + b + cin with optional carry suppression
    function [W:0] au;
        input [W-1:0] a;
        input [W-1:0] b;
        input cin;
        input nocarry;
        begin
            if (nocarry)
                au = {1'b0, a ^ b};
            else
                au = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
        end
    endfunction

    // Relation flags {less, equal, greater} from a difference's zero and sign
    function [2:0] rel_flags;
        input zero;
        input neg;
        begin
            rel_flags[2] = !zero && neg;
            rel_flags[1] = zero;
            rel_flags[0] = !zero && !neg;
        end
    endfunction

    // Operations whose result is clocked into the accumulator
    function writes_acc;
        input [3:0] op;
        begin
            case (op)
                `ALX_OP_ADD, `ALX_OP_SUB, `ALX_OP_XOR: writes_acc = 1'b1;
                `ALX_OP_LDA, `ALX_OP_RUM: writes_acc = 1'b1;
                `ALX_OP_AND, `ALX_OP_OR: writes_acc = 1'b1;
                `ALX_OP_DNG: writes_acc = 1'b1;
                default: writes_acc = 1'b0;
            endcase
        end
    endfunction

    wire [2:0] isel = cmd_q[17:15];
    wire [2:0] isel_even = {isel[2:1], 1'b0};
    wire [OW-1:0] opf = cmd_q[OW-1:0];
    wire in_opc = (st_q == S_OPC);
    wire in_exe = (st_q == S_EXE);
    wire is_atx = (op_q == `ALX_OP_ATX);
    wire is_dng = (op_q == `ALX_OP_DNG);
    wire t5 = (phase_q == `ALX_PH_T5);
    wire t1 = (phase_q == `ALX_PH_T1);

    assign operand_cycle_phase = in_opc;
    assign execute_phase_one = in_exe;
    assign fetch_cycle_phase = in_exe;

    // Adder input selection
    reg [W-1:0] ua, ub;
    reg cin, nocy;
    always @* begin
        ua = {W{1'b0}};
        ub = {W{1'b0}};
        cin = 1'b0;
        nocy = 1'b0;
        if (in_opc && is_atx) begin
            ua = {{(W-OW){1'b0}}, opf};
            ub = (isel != 3'h0) ? {{(W-OW){1'b0}}, idx_q[isel]} : {W{1'b0}};
        end else if (in_opc && is_dng) begin
            ua = ~ext_q;
            cin = 1'b1;
        end else if (in_exe) begin
            case (op_q)
                `ALX_OP_ADD: begin
                    ua = acc_q;
                    ub = buf_q;
                end
                `ALX_OP_SUB, `ALX_OP_CMP: begin
                    ua = acc_q;
                    ub = ~buf_q;
                    cin = 1'b1;
                end
                `ALX_OP_XOR: begin
                    ua = acc_q;
                    ub = buf_q;
                    nocy = 1'b1;
                end
                `ALX_OP_ATX: begin
                    ua = {{(W-OW){1'b0}}, opf};
                    ub = {{(W-OW){1'b1}}, ~idx_q[isel_even]};
                    cin = 1'b1;
                end
                `ALX_OP_DNG: begin
                    ua = ~acc_q;
                    cin = flags_q[`ALX_F_CY];
                end
                default: ub = buf_q;
            endcase
        end
    end

    wire [W:0] sum_full = au(ua, ub, cin, nocy);
    wire [W-1:0] sum = sum_full[W-1:0];
    wire [OW-1:0] dsum = sum[OW-1:0];
    wire [2:0] cmp_rel = rel_flags(sum == {W{1'b0}}, sum[W-1]);
    wire [2:0] idx_rel = rel_flags(dsum == {OW{1'b0}}, dsum[OW-1]);

    // Result path into the accumulator
    reg [W-1:0] acc_in;
    always @* begin
        case (op_q)
            `ALX_OP_RUM: acc_in = (acc_q & ~ext_q) | (sum & ext_q);
            `ALX_OP_AND: acc_in = acc_q & sum;
            `ALX_OP_OR: acc_in = acc_q | sum;
            default: acc_in = sum;
        endcase
    end

    wire acc_op = writes_acc(op_q);
    assign acc_load_pulse = in_exe && t5 && acc_op;
    assign extension_load_pulse = t5 && ((in_exe && op_q == `ALX_OP_LDE) ||
        (in_opc && is_dng));
    // The fetched word arrives at T1 following the operand cycle, i.e. first phase of execution
    wire fetch_op = !is_atx && !is_dng;
    assign buffer_load_pulse = in_exe && fetch_op && t1;
    assign index_write_strobe = in_exe && is_atx && t1 && (isel != 3'h0);

    // AHB-Lite slave: zero wait states, always OKAY
    wire take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rd_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            if (take) begin
                wr_addr_q <= haddr[7:0];
                rd_addr_q <= haddr[7:0];
            end
        end
    end

    always @* begin
        hrdata = 32'h00000000;
        if (rd_pend_q) begin
            case (rd_addr_q)
                `ALX_A_CTRL: hrdata = {28'h0000000, op_q};
                `ALX_A_ACC: hrdata = {8'h00, acc_q};
                `ALX_A_EXT: hrdata = {8'h00, ext_q};
                `ALX_A_BUF: hrdata = {8'h00, buf_q};
                `ALX_A_CMD: hrdata = {8'h00, cmd_q};
                `ALX_A_FLAGS: hrdata = {26'h0000000, flags_q};
                `ALX_A_STAT: hrdata = {27'h0000000, phase_q, st_q};
                `ALX_A_MEM: hrdata = {8'h00, mem_q};
                default: hrdata = 32'h00000000;
            endcase
        end
    end

    wire sw_start = wr_pend_q && (wr_addr_q == `ALX_A_CTRL) && !busy_q &&
        (hwdata[3:0] != `ALX_OP_NONE);
    wire sw_wr = wr_pend_q && !busy_q;

    // Phase counter: T1 to T5, one phase per clock, free running
    reg [2:0] phase_d;
    always @* begin
        if (t5)
            phase_d = `ALX_PH_T1;
        else
            phase_d = phase_q + 3'h1;
    end

    // Next state: operand and execute states each span exactly one T1..T5 memory cycle; idle lasts until busy at T5
    reg [1:0] st_d;
    reg busy_d;
    reg [3:0] op_d;
    always @* begin
        st_d = st_q;
        busy_d = busy_q;
        op_d = op_q;
        if (sw_start) begin
            op_d = hwdata[3:0];
            busy_d = 1'b1;
        end
        case (st_q)
            S_IDLE: begin
                if (busy_q && t5)
                    st_d = S_OPC;
            end
            S_OPC: begin
                if (t5)
                    st_d = S_EXE;
            end
            S_EXE: begin
                if (t5) begin
                    st_d = S_IDLE;
                    busy_d = 1'b0;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= `ALX_PH_T1;
            st_q <= S_IDLE;
            op_q <= `ALX_OP_NONE;
            busy_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            st_q <= st_d;
            op_q <= op_d;
            busy_q <= busy_d;
        end
    end

    // Datapath registers
    integer i;
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            acc_q <= {W{1'b0}};
            ext_q <= {W{1'b0}};
            buf_q <= {W{1'b0}};
            cmd_q <= 24'h000000;
            mem_q <= {W{1'b0}};
            flags_q <= 6'h00;
            for (i = 0; i < 8; i = i + 1)
                idx_q[i] <= {OW{1'b0}};
        end else begin
            if (sw_wr) begin
                case (wr_addr_q)
                    `ALX_A_ACC: acc_q <= hwdata[W-1:0];
                    `ALX_A_EXT: ext_q <= hwdata[W-1:0];
                    `ALX_A_CMD: cmd_q <= hwdata[23:0];
                    `ALX_A_FLAGS: flags_q <= hwdata[5:0];
                    `ALX_A_IDX: idx_q[hwdata[18:16]] <= hwdata[OW-1:0];
                    `ALX_A_MEM: mem_q <= hwdata[W-1:0];
                    default: ;
                endcase
            end
            if (buffer_load_pulse)
                buf_q <= mem_word;
            if (acc_load_pulse)
                acc_q <= acc_in;
            if (extension_load_pulse)
                ext_q <= sum;
            if (in_opc && is_dng && t5)
                flags_q[`ALX_F_CY] <= sum_full[W];
            if (in_opc && is_atx && t5)
                cmd_q[OW-1:0] <= dsum;
            if (in_exe && is_atx && t1) begin
                if (isel != 3'h0)
                    idx_q[isel] <= opf;
                cmd_q[`ALX_ISEL_LSB] <= 1'b0;
            end
            if (in_exe && t5 && op_q == `ALX_OP_ADD)
                flags_q[`ALX_F_OV] <= (acc_q[W-1] == buf_q[W-1]) &&
                    (sum[W-1] != acc_q[W-1]);
            if (in_exe && t5 && op_q == `ALX_OP_CMP) begin
                flags_q[`ALX_F_EQ] <= cmp_rel[1];
                flags_q[`ALX_F_GT] <= cmp_rel[0];
                flags_q[`ALX_F_LT] <= cmp_rel[2];
                flags_q[`ALX_F_BE] <= |(acc_q & buf_q);
            end
            if (in_exe && t5 && is_atx) begin
                flags_q[`ALX_F_EQ] <= idx_rel[1];
                flags_q[`ALX_F_GT] <= idx_rel[0];
                flags_q[`ALX_F_LT] <= idx_rel[2];
            end
        end
    end
endmodule
`default_nettype wire

// [verification/alx_exec_properties.sv]
// Port timing properties of the execution control block
`timescale 1ns/1ps
`default_nettype none
`include "alx_regs.vh"
module alx_exec_checker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [2:0] phase_q,
    input wire logic fetch_cycle_phase,
    input wire logic execute_phase_one,
    input wire logic acc_load_pulse,
    input wire logic extension_load_pulse,
    input wire logic buffer_load_pulse,
    input wire logic index_write_strobe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_exec_cycle;
        execute_phase_one && phase_q == `ALX_PH_T1 ##1 execute_phase_one [*3]
            ##1 execute_phase_one && phase_q == `ALX_PH_T5;
    endsequence
    a_acc_pulse_t5: assert property (acc_load_pulse |-> phase_q == `ALX_PH_T5)
        else $error("accumulator load outside T5");
    a_acc_single_pulse: assert property (acc_load_pulse |=> !acc_load_pulse [*4])
        else $error("accumulator clocked twice in a cycle");
    a_acc_in_fetch: assert property (acc_load_pulse |-> fetch_cycle_phase)
        else $error("accumulator load not overlapped with fetch");
    a_ext_pulse_t5: assert property (extension_load_pulse |-> phase_q == `ALX_PH_T5)
        else $error("extension load outside T5");
    a_buf_pulse_t1: assert property (buffer_load_pulse |-> phase_q == `ALX_PH_T1)
        else $error("buffer load outside T1");
    a_index_write_t1: assert property (index_write_strobe |-> phase_q == `ALX_PH_T1)
        else $error("index write outside T1");
    a_exec_full_span: assert property ($rose(execute_phase_one) |-> s_exec_cycle)
        else $error("execution phase not one whole cycle");
    a_exec_with_fetch: assert property (execute_phase_one |-> fetch_cycle_phase)
        else $error("execution without overlapping fetch");
    a_phase_wraps: assert property (phase_q == `ALX_PH_T5 |=> phase_q == `ALX_PH_T1)
        else $error("phase does not wrap after T5");
endmodule
bind alx_exec alx_exec_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .phase_q(phase_q),
    .fetch_cycle_phase(fetch_cycle_phase), .execute_phase_one(execute_phase_one),
    .acc_load_pulse(acc_load_pulse), .extension_load_pulse(extension_load_pulse),
    .buffer_load_pulse(buffer_load_pulse), .index_write_strobe(index_write_strobe));
`default_nettype wire

// [verification/alx_mem_model.sv]
// Core memory model presenting operand words on the memory output bus
`timescale 1ns/1ps
`default_nettype none
`include "alx_regs.vh"
module alx_mem_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic operand_cycle_phase,
    input wire logic [2:0] phase_q,
    input wire logic [23:0] next_word,
    output logic [23:0] mem_word
);
    logic valid_q;
    logic [23:0] junk_q;
    // Word valid from T4 of the read until the end of T1; otherwise a changing pattern
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            valid_q <= 1'b0;
            junk_q <= 24'h5A5A5A;
        end else begin
            junk_q <= ~junk_q;
            if (operand_cycle_phase && phase_q == `ALX_PH_T3) valid_q <= 1'b1;
            else if (valid_q && phase_q == `ALX_PH_T1) valid_q <= 1'b0;
        end
    end
    assign mem_word = valid_q ? next_word : junk_q;
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the execution control block
`timescale 1ns/1ps
`default_nettype none
`include "alx_regs.vh"
module testbench;
    logic ref_clk, nrst, hwrite, hsel;
    logic [31:0] haddr, hwdata, hrdata, rd, s;
    logic [1:0] htrans;
    logic [2:0] hsize, phase_q;
    logic [23:0] mem_word, word, a, e, b, ea, ee;
    logic [13:0] sum;
    logic [5:0] ef, fm;
    wire hready, hreadyout, hresp, ocp, fcp, exe, alp, elp, blp, iws;
    int fail_count = 0, cmp_count = 0, r, op;
    assign hready = hreadyout;
    alx_exec uut (.ref_clk(ref_clk), .nrst(nrst), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hsel(hsel), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_word(mem_word),
        .phase_q(phase_q), .operand_cycle_phase(ocp), .fetch_cycle_phase(fcp),
        .execute_phase_one(exe), .acc_load_pulse(alp), .extension_load_pulse(elp),
        .buffer_load_pulse(blp), .index_write_strobe(iws));
    alx_mem_model u_mem (.ref_clk(ref_clk), .nrst(nrst), .operand_cycle_phase(ocp),
        .phase_q(phase_q), .next_word(word), .mem_word(mem_word));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic [23:0] f_acc(input [3:0] o, input [23:0] x, y, z);
        case (o)
            `ALX_OP_ADD: f_acc = x + z;
            `ALX_OP_SUB: f_acc = x - z;
            `ALX_OP_XOR: f_acc = x ^ z;
            `ALX_OP_LDA: f_acc = z;
            `ALX_OP_RUM: f_acc = (x & ~y) | (z & y);
            `ALX_OP_AND: f_acc = x & z;
            `ALX_OP_OR: f_acc = x | z;
            `ALX_OP_DNG: f_acc = ~x + {23'h0, y == 24'h0};
            default: f_acc = x;
        endcase
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input w, input [7:0] ad, input [31:0] d);
        @(posedge ref_clk);
        haddr <= {24'h0, ad};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask
    task run_op(input [3:0] o);
        logic [23:0] d;
        logic [13:0] dx;
        d = a - b;
        sum = a[13:0] + e[13:0];
        dx = sum - b[13:0];
        ea = f_acc(o, a, e, b);
        ee = o == `ALX_OP_LDE ? b : o == `ALX_OP_DNG ? ~e + 24'h1 : e;
        fm = 6'h00;
        ef = 6'h00;
        case (o)
            `ALX_OP_ADD: begin
                fm = 6'h01;
                ef[0] = a[23] == b[23] && ea[23] != a[23];
            end
            `ALX_OP_CMP: begin
                fm = 6'h1E;
                ef = {1'b0, |(a & b), d[23], d == 24'h0, !d[23] && d != 24'h0, 1'b0};
            end
            `ALX_OP_ATX: begin
                fm = 6'h0E;
                ef = {2'b00, dx[13], dx == 14'h0, !dx[13] && dx != 14'h0, 1'b0};
                bus(1, `ALX_A_IDX, {13'h0, 3'h3, 2'h0, a[13:0]});
                bus(1, `ALX_A_IDX, {13'h0, 3'h2, 2'h0, b[13:0]});
                bus(1, `ALX_A_CMD, {14'h0, 3'h3, 1'b0, e[13:0]});
            end
            `ALX_OP_DNG: begin
                fm = 6'h20;
                ef[5] = e == 24'h0;
            end
            default: ;
        endcase
        bus(1, `ALX_A_ACC, {8'h00, a});
        bus(1, `ALX_A_EXT, {8'h00, e});
        bus(1, `ALX_A_FLAGS, 32'h0000001E);
        word <= b;
        bus(1, `ALX_A_CTRL, {28'h0, o});
        repeat (30) @(posedge ref_clk);
        bus(0, `ALX_A_STAT, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h0);
        bus(0, `ALX_A_ACC, 32'h0);
        chk(rd, {8'h00, ea});
        bus(0, `ALX_A_EXT, 32'h0);
        chk(rd, {8'h00, ee});
        bus(0, `ALX_A_FLAGS, 32'h0);
        chk({26'h0, rd[5:0] & fm}, {26'h0, ef & fm});
        if (o < `ALX_OP_ATX) begin
            bus(0, `ALX_A_BUF, 32'h0);
            chk(rd, {8'h00, b});
        end
        if (o == `ALX_OP_ATX) begin
            bus(0, `ALX_A_CMD, 32'h0);
            chk(rd, {14'h0, 3'h2, 1'b0, sum});
        end
    endtask
    task test_done;
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        $display("FAIL %0t watchdog expired", $time);
        test_done;
    end
    initial begin
        nrst = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hsel = 1'b1;
        hwdata = 32'h0;
        word = 24'h0;
        s = 32'hEB1E2D8C;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        bus(0, `ALX_A_ACC, 32'h0);
        chk(rd, 32'h0);
        bus(0, 8'h24, 32'h0);
        chk(rd, 32'h0);
        for (r = 0; r < 4; r++) begin
            for (op = 1; op <= 11; op++) begin
                s = lfsr(lfsr(lfsr(s)));
                a = s[23:0];
                s = lfsr(lfsr(lfsr(s)));
                e = s[23:0];
                s = lfsr(lfsr(lfsr(s)));
                b = s[23:0];
                // Corner cases: overflow and zero extension, then equal operands
                if (r == 0) begin
                    a = 24'h7FFFFF;
                    e = 24'h000000;
                    b = 24'h000001;
                end
                if (r == 1) b = a;
                run_op(op[3:0]);
            end
        end
        test_done;
    end
endmodule
`default_nettype wire
